// file: inc/bbs_pkg.sv
// package: constants and types of the bit-banged serial shift master
`default_nettype none
package bbs_pkg;
  // ==========================================================================
  // clock and bit rates
  localparam int         CLK_KHZ      = 10000;
  localparam int         OUT_KBPS     = 800;
  localparam int         IN_KBPS      = 600;
  // rate is a floor, so the cycle count per bit rounds down
  localparam logic [3:0] OUT_HALF_CYC = 4'(CLK_KHZ / OUT_KBPS / 2);
  localparam logic [3:0] IN_HALF_CYC  = 4'(CLK_KHZ / IN_KBPS / 2);
  // ==========================================================================
  // mode field
  localparam logic [1:0] MODE_RST      = 2'h1;
  localparam int         MODE_LSB_BIT  = 0;
  localparam int         MODE_LATE_BIT = 1;
  // ==========================================================================
  // framing
  localparam int         BYTE_BITS    = 8;
  localparam int         NUM_PREFIX   = 3;
  localparam logic [3:0] BITS_NORMAL  = 4'h8;
  localparam logic [3:0] BITS_DUMMY   = 4'h9;
  localparam logic [1:0] PREFIX_END   = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LOAD  = 4'h2,
    ST_SHIFT = 4'h4,
    ST_DONE  = 4'h8
  } bbs_state_t;
endpackage
`default_nettype wire

// file: rtl/bbs_rx_buf.sv
// module: two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bbs_rx_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  // ==========================================================================
  // head feeds the output, spare catches a word while the reader stalls
  logic             spare_v_q;
  logic [WIDTH-1:0] spare_d_q;
  logic             push;
  logic             pop;

  assign in_ready_o = ~spare_v_q;
  assign push       = in_valid_i & ~spare_v_q;
  assign pop        = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
      spare_v_q   <= 1'b0;
      spare_d_q   <= '0;
    end else if (pop || !out_valid_o) begin
      if (spare_v_q) begin
        out_valid_o <= 1'b1;
        out_data_o  <= spare_d_q;
        spare_v_q   <= push;
        spare_d_q   <= in_data_i;
      end else begin
        out_valid_o <= push;
        out_data_o  <= in_data_i;
      end
    end else if (push) begin
      spare_v_q <= 1'b1;
      spare_d_q <= in_data_i;
    end
  end
endmodule
`default_nettype wire

// file: rtl/bbs_shift_master.sv
// module: bit-banged serial shift master with mode, select and shared data pin
// Function
// RULE1: mode 0: msb first, positive clock
// RULE2: mode 1: lsb first, positive clock
// RULE3: modes 2/3: sample from second pulse
// RULE4: mode resets to 1
// RULE5: mode holds for all later transfers
// RULE6: select line low during transfer
// RULE7: no select line: never drive select
// RULE8: one clock pulse per output bit
// RULE9: pins stay driven outputs after sending
// RULE10: send programmed count of bytes
// RULE11: output shifts at 800 kbit/s
// RULE12: up to three optional prefix bytes
// RULE13: shared pin: drive prefixes, then release
// RULE14: input at 600 kbit/s, fill count
// RULE15: clock idles low, modes 2/3 configurable
`timescale 1ns/1ps
`default_nettype none
module bbs_shift_master
  import bbs_pkg::*;
#(
  parameter logic SCK_IDLE_M23 = 1'b0
) (
  input  wire logic       REF_CLK_I,
  input  wire logic       SYS_RST_I,
  input  wire logic       MODE_WR_I,
  input  wire logic [1:0] MODE_I,
  output logic      [1:0] MODE_O,
  input  wire logic       START_OUT_I,
  input  wire logic       START_IN_I,
  input  wire logic       CS_EN_I,
  input  wire logic       SHARED_PIN_I,
  input  wire logic [7:0] BYTE_CNT_I,
  input  wire logic [2:0] PREFIX_EN_I,
  input  wire logic [7:0] PREFIX0_I,
  input  wire logic [7:0] PREFIX1_I,
  input  wire logic [7:0] PREFIX2_I,
  input  wire logic       TX_VALID_I,
  input  wire logic [7:0] TX_DATA_I,
  output logic            TX_READY_O,
  output logic            RX_VALID_O,
  output logic      [7:0] RX_DATA_O,
  input  wire logic       RX_READY_I,
  output logic            BUSY_O,
  output logic            DONE_O,
  output logic            SCK_O,
  output logic            CS_N_O,
  output logic            CS_OE_O,
  output logic            DOUT_O,
  output logic            DOUT_OE_O,
  input  wire logic       DIN_I
);
  // ==========================================================================
  // state
  bbs_state_t st_q;
  logic [1:0] xmode_q;
  logic       xin_q;
  logic       xcs_q;
  logic       xshared_q;
  logic [1:0] pre_idx_q;
  logic [7:0] left_q;
  logic [7:0] sh_q;
  logic [3:0] bits_q;
  logic       half_q;
  logic [3:0] tick_q;
  logic       rxing_q;
  logic       din_s1_q;
  logic       din_s2_q;
  logic       push_q;
  logic [7:0] push_data_q;
  logic       buf_in_ready;
  logic       half_end;
  logic       sck_idle;
  logic       tx_take;
  logic [7:0] pfx [NUM_PREFIX];

  assign pfx[0]   = PREFIX0_I;
  assign pfx[1]   = PREFIX1_I;
  assign pfx[2]   = PREFIX2_I;
  assign half_end = (tick_q == 4'h0);
  assign sck_idle = xmode_q[MODE_LATE_BIT] ? SCK_IDLE_M23 : 1'b0; // RULE15
  assign tx_take  = TX_READY_O & TX_VALID_I;
  assign MODE_O   = xmode_q;

  // ==========================================================================
  // mode setting
  logic [1:0] mode_q;

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      mode_q <= MODE_RST; // RULE4
    end else if (MODE_WR_I) begin
      mode_q <= MODE_I; // RULE5
    end
  end

  // ==========================================================================
  // input synchroniser
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      din_s1_q <= 1'b0;
      din_s2_q <= 1'b0;
    end else begin
      din_s1_q <= DIN_I;
      din_s2_q <= din_s1_q;
    end
  end

  // ==========================================================================
  // half-bit timer
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      tick_q <= OUT_HALF_CYC - 4'h1;
    end else if (st_q != ST_SHIFT || half_end) begin
      tick_q <= (xin_q ? IN_HALF_CYC : OUT_HALF_CYC) - 4'h1; // RULE11 RULE14
    end else begin
      tick_q <= tick_q - 4'h1;
    end
  end

  // ==========================================================================
  // sequencer
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      st_q        <= ST_IDLE;
      xmode_q     <= MODE_RST;
      xin_q       <= 1'b0;
      xcs_q       <= 1'b0;
      xshared_q   <= 1'b0;
      pre_idx_q   <= 2'h0;
      left_q      <= 8'h00;
      sh_q        <= 8'h00;
      bits_q      <= 4'h0;
      half_q      <= 1'b0;
      rxing_q     <= 1'b0;
      push_q      <= 1'b0;
      push_data_q <= 8'h00;
    end else begin
      push_q <= 1'b0;
      unique case (st_q)
        ST_IDLE: begin
          if (START_OUT_I || START_IN_I) begin
            xin_q     <= START_IN_I;
            xmode_q   <= mode_q; // RULE5
            xcs_q     <= CS_EN_I;
            xshared_q <= SHARED_PIN_I;
            left_q    <= BYTE_CNT_I; // RULE10
            pre_idx_q <= 2'h0;
            st_q      <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          half_q <= 1'b0;
          if (xin_q && pre_idx_q != PREFIX_END) begin
            pre_idx_q <= pre_idx_q + 2'h1;
            if (PREFIX_EN_I[pre_idx_q]) begin // RULE12
              sh_q    <= pfx[pre_idx_q];
              rxing_q <= 1'b0;
              bits_q  <= BITS_NORMAL;
              st_q    <= ST_SHIFT;
            end
          end else if (left_q == 8'h00) begin
            st_q <= ST_DONE;
          end else if (!xin_q) begin
            if (tx_take) begin
              sh_q    <= TX_DATA_I;
              rxing_q <= 1'b0;
              bits_q  <= BITS_NORMAL;
              st_q    <= ST_SHIFT;
            end
          end else if (buf_in_ready && !push_q) begin
            // a byte starts only when the buffer can take it, so none is lost
            rxing_q <= 1'b1;
            bits_q  <= xmode_q[MODE_LATE_BIT] ? BITS_DUMMY : BITS_NORMAL; // RULE3
            st_q    <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (half_end && !half_q) begin
            half_q <= 1'b1;
            if (rxing_q && bits_q != BITS_DUMMY) begin // RULE3
              if (xmode_q[MODE_LSB_BIT]) begin
                sh_q <= {din_s2_q, sh_q[7:1]};
              end else begin
                sh_q <= {sh_q[6:0], din_s2_q};
              end
            end
          end else if (half_end) begin
            half_q <= 1'b0;
            bits_q <= bits_q - 4'h1;
            if (!rxing_q) begin
              sh_q <= xmode_q[MODE_LSB_BIT] ? (sh_q >> 1) : (sh_q << 1); // RULE1 RULE2
            end
            if (bits_q == 4'h1) begin
              st_q <= ST_LOAD;
              if (rxing_q) begin
                left_q      <= left_q - 8'h01; // RULE14
                push_q      <= 1'b1;
                push_data_q <= sh_q;
              end else if (!xin_q) begin
                left_q <= left_q - 8'h01; // RULE10
              end
            end
          end
        end
        ST_DONE: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // handshake and status outputs
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      TX_READY_O <= 1'b0;
      BUSY_O     <= 1'b0;
      DONE_O     <= 1'b0;
    end else begin
      TX_READY_O <= (st_q == ST_LOAD) && !xin_q && (left_q != 8'h00) && !tx_take;
      BUSY_O     <= (st_q != ST_IDLE) || START_OUT_I || START_IN_I;
      DONE_O     <= (st_q == ST_DONE);
    end
  end

  // ==========================================================================
  // pins
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      SCK_O     <= 1'b0;
      CS_N_O    <= 1'b1;
      CS_OE_O   <= 1'b0;
      DOUT_O    <= 1'b0;
      DOUT_OE_O <= 1'b0;
    end else begin
      SCK_O <= ((st_q == ST_SHIFT) && half_q) ^ sck_idle; // RULE8 RULE15
      if (st_q == ST_IDLE && (START_OUT_I || START_IN_I) && CS_EN_I) begin // RULE7
        CS_N_O  <= 1'b0; // RULE6
        CS_OE_O <= 1'b1; // RULE9
      end else if (st_q == ST_DONE && xcs_q) begin
        CS_N_O <= 1'b1;
      end
      if (st_q == ST_SHIFT && !rxing_q) begin
        DOUT_O    <= xmode_q[MODE_LSB_BIT] ? sh_q[0] : sh_q[7]; // RULE1 RULE2
        DOUT_OE_O <= 1'b1; // RULE9 RULE13
      end else if (st_q == ST_SHIFT && xshared_q) begin
        DOUT_OE_O <= 1'b0; // RULE13
      end
    end
  end

  bbs_rx_buf #(
    .WIDTH(BYTE_BITS)
  ) u_rx_buf (
    .clk_i       (REF_CLK_I),
    .rst_i       (SYS_RST_I),
    .in_valid_i  (push_q),
    .in_data_i   (push_data_q),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (RX_VALID_O),
    .out_data_o  (RX_DATA_O),
    .out_ready_i (RX_READY_I)
  );

  // ==========================================================================
  // checks
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic sck_act;
  assign sck_act = SCK_O ^ sck_idle;

  chk_msb_order: assert property ($rose(sck_act) && !rxing_q && !xmode_q[0] |-> DOUT_O == sh_q[7]) // RULE1
    else $error("msb-first bit wrong");
  chk_lsb_order: assert property ($rose(sck_act) && !rxing_q && xmode_q[0] |-> DOUT_O == sh_q[0]) // RULE2
    else $error("lsb-first bit wrong");
  chk_dummy_pulse: assert property (st_q == ST_SHIFT && bits_q == BITS_DUMMY |-> xmode_q[1] && rxing_q) // RULE3
    else $error("dummy pulse outside late modes");
  chk_mode_reset: assert property ($fell(SYS_RST_I) |-> mode_q == MODE_RST) // RULE4
    else $error("mode not reset to one");
  chk_mode_held: assert property (st_q == ST_SHIFT |=> $stable(xmode_q)) // RULE5
    else $error("mode changed inside transfer");
  chk_cs_low: assert property (st_q == ST_SHIFT && xcs_q |-> !CS_N_O && CS_OE_O) // RULE6
    else $error("select not low during transfer");
  chk_nocs_still: assert property (st_q != ST_IDLE && !xcs_q |=> $stable(CS_N_O) && $stable(CS_OE_O)) // RULE7
    else $error("select touched without select line");
  chk_out_rate: assert property ($rose(sck_act) && !xin_q |-> sck_act[*6] ##1 !sck_act) // RULE11
    else $error("output half period wrong");
  chk_in_rate: assert property ($rose(sck_act) && xin_q |-> sck_act[*8] ##1 !sck_act) // RULE14
    else $error("input half period wrong");
  chk_shared_off: assert property (st_q == ST_SHIFT && rxing_q && xshared_q |=> !DOUT_OE_O) // RULE13
    else $error("shared pin still driven");
  chk_pins_kept: assert property (DONE_O && !xin_q && xcs_q |-> CS_OE_O && CS_N_O) // RULE9
    else $error("select not left driven high");
  chk_count_done: assert property (st_q == ST_DONE |-> left_q == 8'h00) // RULE10
    else $error("transfer ended early");

  cov_out_xfer: cover property (DONE_O && !xin_q);
  cov_in_late: cover property (DONE_O && xin_q && xmode_q == 2'h3);
  cov_buf_full: cover property (!buf_in_ready && !RX_READY_I);
  cov_prefix: cover property (st_q == ST_SHIFT && xin_q && !rxing_q);
endmodule
`default_nettype wire

// file: tb/bbs_periph_model.sv
// partner model: serial peripheral that captures and answers bytes
`timescale 1ns/1ps
`default_nettype none
module bbs_periph_model (
  input  wire logic        clk_i,
  input  wire logic        arm_i,
  input  wire logic        drive_i,
  input  wire logic        late_i,
  input  wire logic        lsb_i,
  input  wire logic [7:0]  skip_i,
  input  wire logic [7:0]  resp_i,
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        data_i,
  output logic             data_o,
  output logic      [15:0] cap_o,
  output logic      [7:0]  rises_o,
  output logic             cs_low_o
);
  logic       sck_q;
  logic       last_q;
  logic [7:0] falls_q;
  logic [7:0] pos;
  logic [7:0] bit_n;
  always_ff @(posedge clk_i) begin
    sck_q  <= sck_i;
    // cleared while disarmed so the toggling idle line never starts unknown
    last_q <= arm_i ? data_o : 1'b0;
    if (!arm_i) begin
      falls_q  <= 8'h00;
      rises_o  <= 8'h00;
      cs_low_o <= 1'b0;
    end else begin
      if (!cs_n_i) cs_low_o <= 1'b1;
      if (sck_i && !sck_q) rises_o <= rises_o + 8'h01;
      if (sck_i && !sck_q) cap_o <= {cap_o[14:0], data_i};
      if (!sck_i && sck_q) falls_q <= falls_q + 8'h01;
    end
  end
  // released line toggles, so a stale bit never reads as valid
  always_comb begin
    pos   = (falls_q - skip_i) % (late_i ? 8'h09 : 8'h08);
    bit_n = late_i ? pos - 8'h01 : pos;
    if (!arm_i || !drive_i || falls_q < skip_i || (late_i && pos == 8'h00)) data_o = ~last_q;
    else data_o = lsb_i ? resp_i[bit_n[2:0]] : resp_i[3'h7 - bit_n[2:0]];
  end
endmodule
`default_nettype wire

// file: tb/test_bitbang_serial_shift_master.sv
// testbench: self-checking bench of the serial shift master
`timescale 1ns/1ps
`default_nettype none
module test_bitbang_serial_shift_master;
  import bbs_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, mwr = 1'b0, so = 1'b0, si = 1'b0, cs_en = 1'b0;
  logic        shr = 1'b0, txv = 1'b0, rxr = 1'b0, arm = 1'b0, drv = 1'b0, seen = 1'b0;
  logic        txr, rxv, busy, done, sck, cs_n, cs_oe, dout, doe, din, pdat, csl;
  logic        sck_q = 1'b0;
  logic [1:0]  mode = 2'h0, mode_o;
  logic [2:0]  pen = 3'h0;
  logic [7:0]  cnt = 8'h00, txd = 8'h00, skip = 8'h00, resp = 8'h00, rxd, rises;
  logic [7:0]  per = 8'h00, gap = 8'h00;
  logic [15:0] cap;
  int          error_cnt = 0, check_count = 0, cyc = 0;
  always #50 clk = ~clk;
  assign din = (shr && doe) ? dout : pdat;
  bbs_shift_master uut (.REF_CLK_I(clk), .SYS_RST_I(rst), .MODE_WR_I(mwr), .MODE_I(mode),
    .MODE_O(mode_o), .START_OUT_I(so), .START_IN_I(si), .CS_EN_I(cs_en), .SHARED_PIN_I(shr),
    .BYTE_CNT_I(cnt), .PREFIX_EN_I(pen), .PREFIX0_I(8'h96), .PREFIX1_I(8'h5A),
    .PREFIX2_I(8'hE1), .TX_VALID_I(txv), .TX_DATA_I(txd), .TX_READY_O(txr), .RX_VALID_O(rxv),
    .RX_DATA_O(rxd), .RX_READY_I(rxr), .BUSY_O(busy), .DONE_O(done), .SCK_O(sck),
    .CS_N_O(cs_n), .CS_OE_O(cs_oe), .DOUT_O(dout), .DOUT_OE_O(doe), .DIN_I(din));
  bbs_periph_model peer (.clk_i(clk), .arm_i(arm), .drive_i(drv), .late_i(mode[1]),
    .lsb_i(mode[0]), .skip_i(skip), .resp_i(resp), .sck_i(sck), .cs_n_i(cs_n),
    .data_i(shr ? din : dout), .data_o(pdat), .cap_o(cap), .rises_o(rises), .cs_low_o(csl));
  // ==========================================================================
  // bit period monitor, sticky done, hang guard
  always @(posedge clk) begin
    sck_q <= sck;
    gap <= gap + 8'h01;
    cyc <= cyc + 1;
    if (sck && !sck_q) per <= gap + 8'h01;
    if (sck && !sck_q) gap <= 8'h00;
    seen <= (seen || done) && !(si || so);
    if (cyc == 20000) error_cnt++;
    if (cyc == 20000) end_of_test();
  end
  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(negedge clk);
    mode = m;
    mwr = 1'b1;
    @(negedge clk);
    mwr = 1'b0;
  endtask
  // tx holds two bytes, first in the upper half
  task automatic go(input logic in, input logic [7:0] n, input logic [15:0] tx);
    @(negedge clk);
    arm = 1'b0;
    cnt = n;
    si = in;
    so = !in;
    @(negedge clk);
    arm = 1'b1;
    si = 1'b0;
    so = 1'b0;
    txv = !in;
    for (int k = 0; k < n && !in; k++) begin
      txd = k ? tx[7:0] : tx[15:8];
      for (int w = 0; w < 200 && txr !== 1'b1; w++) @(negedge clk);
      chk({15'h0, txr}, 16'h1);
      @(negedge clk);
    end
    txv = 1'b0;
  endtask
  task automatic wait_done();
    for (int w = 0; w < 3000 && !seen; w++) @(negedge clk);
    chk({15'h0, seen}, 16'h1);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk(mode_o, 2'h1);
    chk({cs_oe, doe, sck}, 3'h0);
  endtask
  task automatic s_out_msb();
    set_mode(2'h0);
    cs_en = 1'b1;
    go(1'b0, 8'h1, 16'hA500);
    wait_done();
    chk(cap[7:0], 8'hA5);
    chk(rises, 8'h08);
    chk(csl, 1'b1);
    chk({cs_oe, doe, cs_n}, 3'h7);
    chk(per, 8'(2 * OUT_HALF_CYC));
  endtask
  // mode rewritten mid-run must not touch the running transfer
  task automatic s_out_lsb();
    set_mode(2'h1);
    cs_en = 1'b0;
    go(1'b0, 8'h2, 16'h1D62);
    set_mode(2'h0);
    wait_done();
    chk(cap, 16'hB846);
    chk(mode_o, 2'h1);
    chk(csl, 1'b0);
    chk(rises, 8'h10);
  endtask
  task automatic s_in(input logic [1:0] m, input logic sh, input logic [2:0] pe,
                      input logic [7:0] r, input logic [7:0] n, input logic stall);
    logic doe0;
    set_mode(m);
    shr = sh;
    cs_en = 1'b1;
    pen = pe;
    resp = r;
    drv = 1'b1;
    skip = 8'((pe[0] + pe[1] + pe[2]) * 8);
    // data enable only moves for prefixes or a shared-pin release
    doe0 = doe;
    go(1'b1, n, 16'h0);
    if (stall) begin
      repeat (700) @(negedge clk);
      chk({busy, sck}, 2'h2);
      chk(rises, 8'h10);
    end
    for (int k = 0; k < n; k++) begin
      for (int w = 0; w < 1000 && rxv !== 1'b1; w++) @(negedge clk);
      chk({15'h0, rxv}, 16'h1);
      chk(rxd, r);
      rxr = 1'b1;
      @(negedge clk);
      rxr = 1'b0;
      @(negedge clk);
    end
    wait_done();
    chk(rises, 8'(skip + n * (m[1] ? 9 : 8)));
    chk(per, 8'(2 * IN_HALF_CYC));
    chk(doe, sh ? 1'b0 : ((pe != 3'h0) ? 1'b1 : doe0));
    drv = 1'b0;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    t_reset();
    s_out_msb();
    s_out_lsb();
    s_in(2'h0, 1'b1, 3'h5, 8'h4B, 8'h1, 1'b0);
    s_in(2'h1, 1'b0, 3'h0, 8'h4B, 8'h3, 1'b1);
    s_in(2'h2, 1'b1, 3'h7, 8'h2D, 8'h1, 1'b0);
    s_in(2'h3, 1'b0, 3'h2, 8'h4B, 8'h2, 1'b0);
    end_of_test();
  end
endmodule
`default_nettype wire
